// ===== design/jack_sense_defines.svh
// Constants of the jack-detect control block: offsets, fields, resets,
// timing. Assumes inclusion by the design modules and the test bench.
`ifndef JACK_SENSE_DEFINES_SVH
`define JACK_SENSE_DEFINES_SVH

// Each register is one aligned word; byte address is four times the index
`define JDC_INDEX         8'h72
`define CFG_INDEX         8'h80
`define JDC_OFFSET        10'h1c8
`define CFG_OFFSET        10'h200
`define JDC_RESET         16'h0000
`define CFG_RESET         16'h0000
`define JDC_SPREAD_BIT    15
`define JDC_DMX1_BIT      14
`define JDC_DMX0_BIT      13
`define JDC_MUTE_LSB      10
`define JDC_EQB1_BIT      9
`define JDC_EQB0_BIT      8
`define JDC_MODE1_BIT     5
`define JDC_MODE0_BIT     4
`define JDC_LVL1_BIT      3
`define JDC_LVL0_BIT      2
`define JDC_IRQ1_BIT      1
`define JDC_IRQ0_BIT      0
`define JDC_RW_MASK       16'hff33
`define CFG_PATH_BIT      0
`define CFG_DOWNMIX_SELECT_LSB      1
`define GLITCH_NS         1000
`define CLK_NS            25
`define GLITCH_CYCLES     ((`GLITCH_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== design/jack_sense_pkg.sv
// Types of the jack-detect control block.
// Assumes the defines header sits beside it.
package jack_sense_pkg;
    typedef enum logic [2:0]
    {
        MUTE_NONE    = 3'b000,
        MUTE_LINE    = 3'b001,
        MUTE_HP      = 3'b010,
        MUTE_RSV3    = 3'b011,
        MUTE_REAR    = 3'b100,
        MUTE_HP_LINE = 3'b101,
        MUTE_RSV6    = 3'b110,
        MUTE_RSV7    = 3'b111
    } mute_sel_t;
    typedef enum logic [1:0]
    {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } resp_t;
endpackage

// ===== design/jack_detect_filter.sv
// Synchroniser and glitch filter for one jack-detect pin.
// Assumes an asynchronous pin and the register clock.
`timescale 1ns/100ps
`include "jack_sense_defines.svh"

module jack_detect_filter
#(
    parameter int STABLE_CYCLES = `GLITCH_CYCLES
)
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pin,
    output logic      level,
    output logic      change
);
    logic       sync1_q;
    logic       sync2_q;
    logic       level_q;
    logic       level_d;
    logic       change_q;
    logic       change_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // Count how long the synced level has differed from the held one
    always_comb
    begin
        level_d  = level_q;
        change_d = 1'b0;
        cnt_d    = 8'h00;
        if (sync2_q != level_q)
        begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_q == 8'(STABLE_CYCLES - 1))
            begin
                level_d  = sync2_q;
                change_d = 1'b1;
                cnt_d    = 8'h00;
            end
        end
    end

    // Two-flop synchroniser and filter state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_q  <= 1'b0;
            sync2_q  <= 1'b0;
            level_q  <= 1'b0;
            change_q <= 1'b0;
            cnt_q    <= 8'h00;
        end
        else
        begin
            sync1_q  <= pin;
            sync2_q  <= sync1_q;
            level_q  <= level_d;
            change_q <= change_d;
            cnt_q    <= cnt_d;
        end
    end

    assign level  = level_q;
    assign change = change_q;
endmodule // jack_detect_filter

// ===== design/jack_sense_mute_control.sv
// Jack-detect control: AXI4-Lite register, flags, gating and mutes.
// Assumes detect pins are asynchronous and the bus master is well behaved.
`timescale 1ns/100ps
`include "jack_sense_defines.svh"

// What this block does
// - A filtered detect-level change sets that input's interrupt flag.
// - Writing zero clears a flag; only that and reset drop it.
// - Writing one to a flag sets it, giving a software interrupt.
// - System interrupt is the OR of the detect flags whose mode bit is one.
// - Path zero uses slot 12 bit 0; path one uses slot 6 valid.
// - Level bits show live detect states and ignore writes.
// - Mode bit one lets an input's flag raise the interrupt.
// - EQ bypass when enable set and that input is high.
// - Down-mix six-to-two when enable set and that input is high.
// - Down-mix select: 0x none, 10 centre and bass, 11 plus surround.
// - Spread gate enable lets active inputs turn on spreading.
// - 001: input one low mutes line, centre, rear; high mutes mono.
// - 010: input one low mutes headphone, centre, rear; high mono.
// - 100: per-state mute table on both inputs.
// - 101: input one low mutes all but mono; high mutes mono.
// - Forced mute overrides volume; otherwise volume mute applies.
// - A plug reads one, an empty jack reads zero.
// - Register resets to zero; level bits and reserved bits 7:6 are read-only.
// - Field layout at index 0x72 (byte offset 0x1c8) as defined in the header.
module jack_sense_mute_control
    import jack_sense_pkg::*;
#(
    parameter int STABLE_CYCLES = `GLITCH_CYCLES
)
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        jack_detect_zero,
    input  wire logic        jack_detect_one,
    input  wire logic [4:0]  volume_mute,
    output logic             irq_slot12_bit0,
    output logic             irq_slot6_valid,
    output logic             eq_bypass,
    output logic             downmix_active,
    output logic             downmix_center_bass,
    output logic             downmix_surround,
    output logic             spread_active,
    output logic [4:0]       forced_silence,
    output logic [4:0]       output_muted
);
    logic [15:0] jdc_q;
    logic [15:0] jdc_d;
    logic [2:0]  cfg_q;
    logic [2:0]  cfg_d;
    logic [9:0]  awaddr_q;
    logic [9:0]  awaddr_d;
    logic        aw_have_q;
    logic        aw_have_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [1:0]  wstrb_q;
    logic [1:0]  wstrb_d;
    logic        w_have_q;
    logic        w_have_d;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic [1:0]  level;
    logic [1:0]  change;
    logic        irq_any;
    logic        do_write;
    logic [4:0]  mute_raw;
    // Down-mix gate from the detect inputs
    logic        jack_dmx;

    // Register decode shared by read and write paths; each register is
    // one aligned word at four times its index, so odd bytes never match
    function automatic logic [1:0] decode(input logic [9:0] addr);
        decode = 2'b00;
        if (addr == `JDC_OFFSET)
            decode = 2'b01;
        else if (addr == `CFG_OFFSET)
            decode = 2'b10;
    endfunction

    // Detect pin conditioning; plug in reads high via pull-up
    // Each pin has its own synchroniser and glitch filter
    jack_detect_filter #(.STABLE_CYCLES(STABLE_CYCLES)) u_flt0
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (jack_detect_zero),
        .level   (level[0]),
        .change  (change[0])
    );
    jack_detect_filter #(.STABLE_CYCLES(STABLE_CYCLES)) u_flt1
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin     (jack_detect_one),
        .level   (level[1]),
        .change  (change[1])
    );

    // Write channel capture and register update
    always_comb
    begin
        awaddr_d  = awaddr_q;
        aw_have_d = aw_have_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        w_have_d  = w_have_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        jdc_d     = jdc_q;
        cfg_d     = cfg_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            awaddr_d  = s_axi_awaddr;
            aw_have_d = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb[1:0];
            w_have_d = 1'b1;
        end
        if (do_write)
        begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            case (decode(awaddr_q))
                2'b01:
                begin
                    if (wstrb_q[0])
                        jdc_d[7:0] = wdata_q[7:0] & 8'(`JDC_RW_MASK);
                    if (wstrb_q[1])
                        jdc_d[15:8] = wdata_q[15:8];
                end
                2'b10:
                begin
                    if (wstrb_q[0])
                        cfg_d = wdata_q[2:0];
                end
                default:
                    bresp_d = RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready)
            bvalid_d = 1'b0;
        // Flags: write 0 clears, write 1 sets, detect event sets last
        if (!(do_write && decode(awaddr_q) == 2'b01 && wstrb_q[0]))
            jdc_d[1:0] = jdc_q[1:0];
        jdc_d[1:0] = jdc_d[1:0] | change;
        // Level bits mirror the filtered pins; writes never stick
        jdc_d[3:2] = level;
        // Reserved bits always read as zero
        jdc_d[7:6] = 2'b00;
    end

    assign do_write      = aw_have_q && w_have_q && !bvalid_q;
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // Read channel: one outstanding read, answered next cycle
    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            case (decode(s_axi_araddr))
                2'b01:   rdata_d = {16'h0000, jdc_q};
                2'b10:   rdata_d = {29'h0, cfg_q};
                default:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            rvalid_d = 1'b0;
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Register all bus and control state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            jdc_q     <= `JDC_RESET;
            cfg_q     <= 3'(`CFG_RESET);
            awaddr_q  <= 10'h000;
            aw_have_q <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 2'h0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= 2'h0;
        end
        else
        begin
            jdc_q     <= jdc_d;
            cfg_q     <= cfg_d;
            awaddr_q  <= awaddr_d;
            aw_have_q <= aw_have_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            w_have_q  <= w_have_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // Interrupt combine, gated by mode, and path steering
    // Mode zero leaves a set flag for software to poll
    assign irq_any = (jdc_q[`JDC_IRQ0_BIT] & jdc_q[`JDC_MODE0_BIT])
                   | (jdc_q[`JDC_IRQ1_BIT] & jdc_q[`JDC_MODE1_BIT]);
    assign irq_slot12_bit0 = irq_any & !cfg_q[`CFG_PATH_BIT];
    assign irq_slot6_valid = irq_any & cfg_q[`CFG_PATH_BIT];

    // Jack-gated audio functions
    assign eq_bypass = (jdc_q[`JDC_EQB0_BIT] & jdc_q[`JDC_LVL0_BIT])
                     | (jdc_q[`JDC_EQB1_BIT] & jdc_q[`JDC_LVL1_BIT]);
    // Down-mix asked for by a plugged jack whose enable is set
    assign jack_dmx = (jdc_q[`JDC_DMX0_BIT] & jdc_q[`JDC_LVL0_BIT])
                    | (jdc_q[`JDC_DMX1_BIT] & jdc_q[`JDC_LVL1_BIT]);
    assign downmix_active = jack_dmx | cfg_q[`CFG_DOWNMIX_SELECT_LSB + 1];
    // Jack-gated down-mix is the full six-to-two form
    assign downmix_center_bass = downmix_active;
    // Surround joins for select 11 or whenever a jack gates the mix
    assign downmix_surround = jack_dmx
                            | (cfg_q[`CFG_DOWNMIX_SELECT_LSB + 1]
                               & cfg_q[`CFG_DOWNMIX_SELECT_LSB]);
    assign spread_active = jdc_q[`JDC_SPREAD_BIT]
                         & (jdc_q[`JDC_LVL0_BIT] | jdc_q[`JDC_LVL1_BIT]);

    // Mute table; bits are {mono, rear, centre/bass, line, headphone}
    always_comb
    begin
        mute_raw = 5'h00;
        case (mute_sel_t'(jdc_q[`JDC_MUTE_LSB +: 3]))
            MUTE_LINE:
                mute_raw = jdc_q[`JDC_LVL1_BIT] ? 5'h10 : 5'h0e;
            MUTE_HP:
                mute_raw = jdc_q[`JDC_LVL1_BIT] ? 5'h10 : 5'h0d;
            MUTE_REAR:
            begin
                if (jdc_q[`JDC_LVL1_BIT])
                    mute_raw = 5'h1e;
                else if (jdc_q[`JDC_LVL0_BIT])
                    mute_raw = 5'h10;
                else
                    mute_raw = 5'h0e;
            end
            MUTE_HP_LINE:
                mute_raw = jdc_q[`JDC_LVL1_BIT] ? 5'h10 : 5'h0f;
            default:
                mute_raw = 5'h00;
        endcase
    end

    assign forced_silence = mute_raw;
    assign output_muted   = mute_raw | volume_mute;
endmodule // jack_sense_mute_control

// ===== test/jack_sense_checker.sv
// Output relations of the jack-detect block, checked at its ports.
// Assumes binding into jack_sense_mute_control.
`timescale 1ns/100ps
module jack_sense_checker
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [4:0]  volume_mute,
    input wire logic [4:0]  forced_silence,
    input wire logic [4:0]  output_muted,
    input wire logic        irq_slot12_bit0,
    input wire logic        irq_slot6_valid,
    input wire logic        downmix_center_bass,
    input wire logic        downmix_surround
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Mute merge, table shape and interrupt steering
    a_mute_follow: assert property (output_muted == (forced_silence | volume_mute))
        else $error("muted outputs differ from forced or volume mute");
    a_rear_with_cbass: assert property (forced_silence[3] == forced_silence[2])
        else $error("rear and centre mutes disagree");
    a_mono_keeps_hp: assert property (forced_silence[4] |-> !forced_silence[0])
        else $error("headphone forced together with mono");
    a_cbass_with_front: assert property (forced_silence[2] |-> |forced_silence[1:0])
        else $error("centre muted without a front output");
    a_irq_one_path: assert property (!(irq_slot12_bit0 && irq_slot6_valid))
        else $error("interrupt on both paths");
    a_surround_needs_cb: assert property (downmix_surround |-> downmix_center_bass)
        else $error("surround summed without centre and bass");
    // Register read answers one cycle after the address and holds
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> forced_silence == 5'h00 && !irq_slot12_bit0 && !irq_slot6_valid)
        else $error("outputs not cleared by reset");

    c_mono: cover property (forced_silence[4]);
    c_slot6: cover property (irq_slot6_valid);
    c_surround: cover property (downmix_surround);
endmodule // jack_sense_checker

bind jack_sense_mute_control jack_sense_checker i_chk (.aclk, .aresetn,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .volume_mute, .forced_silence, .output_muted,
    .irq_slot12_bit0, .irq_slot6_valid, .downmix_center_bass,
    .downmix_surround);

// ===== test/jack_plug_model.sv
// Two audio jacks with detect switches on the detect resistor network.
// Assumes the bench inserts and removes plugs.
`timescale 1ns/100ps
module jack_plug_model
(
    input  wire logic plug_zero,
    input  wire logic plug_one,
    output logic      pin_zero,
    output logic      pin_one
);
    // Insertion lets the pull-up win; an empty jack's load pulls low
    assign pin_zero = plug_zero;
    assign pin_one  = plug_one;
endmodule // jack_plug_model

// ===== test/jack_sense_mute_control_test.sv
// Self-checking bench of the jack-detect block over AXI4-Lite.
// Assumes the jack model and the bound checker.
`timescale 1ns/100ps
`include "jack_sense_defines.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module jack_sense_mute_control_test;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        plug_zero = 1'b0, plug_one = 1'b0;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h3;
    logic [4:0]  volume_mute = 5'h00, forced_silence, output_muted;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, wb;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, irq_slot12_bit0, irq_slot6_valid, eq_bypass;
    logic        downmix_active, downmix_center_bass, downmix_surround;
    logic        spread_active, jack_detect_zero, jack_detect_one;
    logic [15:0] rd;
    int          fails = 0, n_checks = 0, cyc = 0;

    always #12.5 aclk = ~aclk;

    jack_plug_model i_jacks (.plug_zero, .plug_one,
        .pin_zero(jack_detect_zero), .pin_one(jack_detect_one));
    jack_sense_mute_control #(.STABLE_CYCLES(4)) i_dut (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .jack_detect_zero, .jack_detect_one, .volume_mute,
        .irq_slot12_bit0, .irq_slot6_valid, .eq_bypass, .downmix_active,
        .downmix_center_bass, .downmix_surround, .spread_active,
        .forced_silence, .output_muted);

    // Bus write: address and data offered together, each released when taken
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        bit aw = 0;
        bit w = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) aw = 1;
            if (s_axi_wvalid && s_axi_wready === 1'b1) w = 1;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        wb = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Bus read: result in rd, response code in rr
    task automatic rdr(input logic [9:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata[15:0];
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Plug change, then the filter's settling time
    task automatic plugs(input logic z, input logic o);
        plug_zero <= z;
        plug_one <= o;
        repeat (20) @(posedge aclk);
    endtask

    // Forced mutes {mono,rear,cbass,line,hp} per selector and plug states
    function automatic logic [4:0] mexp(input int s, input int p);
        case (s)
            1: return p[1] ? 5'h10 : 5'h0e;
            2: return p[1] ? 5'h10 : 5'h0d;
            4: return p[1] ? 5'h1e : (p[0] ? 5'h10 : 5'h0e);
            5: return p[1] ? 5'h10 : 5'h0f;
            default: return 5'h00;
        endcase
    endfunction

    // Reset value, unmapped address, set and clear of flags by software
    task automatic t_flags;
        rdr(`JDC_OFFSET);
        `CHK(rd, 16'h0000)
        rdr(10'h072);
        `CHK(rr, 2'b10)
        wr(10'h072, 16'h0000);
        `CHK(wb, 2'b10)
        wr(`JDC_OFFSET, 16'hffff);
        `CHK(wb, 2'b00)
        rdr(`JDC_OFFSET);
        `CHK(rd, 16'hff33)
        `CHK(irq_slot12_bit0, 1'b1)
        wr(`JDC_OFFSET, 16'hff30);
        rdr(`JDC_OFFSET);
        `CHK(rd, 16'hff30)
        `CHK(irq_slot12_bit0, 1'b0)
    endtask

    // Detect events, interrupt mode and polling, both interrupt paths
    task automatic t_event;
        wr(`JDC_OFFSET, 16'h0020);
        plugs(1'b0, 1'b1);
        rdr(`JDC_OFFSET);
        `CHK(rd, 16'h002a)
        `CHK(irq_slot12_bit0, 1'b1)
        wr(`CFG_OFFSET, 16'h0001);
        `CHK(irq_slot6_valid, 1'b1)
        `CHK(irq_slot12_bit0, 1'b0)
        wr(`JDC_OFFSET, 16'h0020);
        `CHK(irq_slot6_valid, 1'b0)
        wr(`JDC_OFFSET, 16'h0000);
        plugs(1'b0, 1'b0);
        rdr(`JDC_OFFSET);
        `CHK(rd, 16'h0002)
        `CHK(irq_slot6_valid, 1'b0)
        plug_zero <= 1'b1;
        repeat (2) @(posedge aclk);
        plugs(1'b0, 1'b0);
        rdr(`JDC_OFFSET);
        `CHK(rd, 16'h0002)
        wr(`CFG_OFFSET, 16'h0000);
    endtask

    // Every selector code against every plug state
    task automatic t_mutes;
        volume_mute <= 5'h01;
        for (int p = 0; p < 4; p++)
        begin
            plugs(p[0], p[1]);
            for (int s = 0; s < 8; s++)
            begin
                wr(`JDC_OFFSET, {3'b000, s[2:0], 10'h000});
                `CHK(forced_silence, mexp(s, p))
                `CHK(output_muted, mexp(s, p) | 5'h01)
            end
        end
    endtask

    // Equalizer bypass, down-mix and spread gating by detect inputs
    task automatic t_gating;
        wr(`JDC_OFFSET, 16'h0100);
        `CHK(eq_bypass, 1'b1)
        wr(`JDC_OFFSET, 16'h4000);
        `CHK(eq_bypass, 1'b0)
        `CHK(downmix_active, 1'b1)
        `CHK(downmix_surround, 1'b1)
        wr(`JDC_OFFSET, 16'h8000);
        `CHK(downmix_active, 1'b0)
        `CHK(spread_active, 1'b1)
        plugs(1'b0, 1'b0);
        `CHK(spread_active, 1'b0)
        wr(`JDC_OFFSET, 16'h0300);
        `CHK(eq_bypass, 1'b0)
        wr(`CFG_OFFSET, 16'h0004);
        `CHK(downmix_center_bass, 1'b1)
        `CHK(downmix_surround, 1'b0)
        wr(`JDC_OFFSET, 16'h2000);
        plugs(1'b1, 1'b0);
        `CHK(downmix_surround, 1'b1)
        plugs(1'b0, 1'b0);
        wr(`CFG_OFFSET, 16'h0006);
        `CHK(downmix_surround, 1'b1)
        wr(`CFG_OFFSET, 16'h0000);
        `CHK(downmix_center_bass, 1'b0)
    endtask

    // Counts and verdict
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog against a hung handshake
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            fails++;
            conclude;
        end
    end

    // Main sequence
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_flags;
        t_event;
        t_mutes;
        t_gating;
        conclude;
    end
endmodule // jack_sense_mute_control_test
